/* hw/byte_rotate_unit.sv */
// Purpose: rotate execution unit with AXI4-Lite register access
// Assumes: single clock aclk, synchronous active-low reset aresetn
// Notes:   writing the instruction register while idle starts one four-phase cycle; an illegal opcode returns to idle after decode
//
// Functional notes
// RQ1 - decode rotate left plain opcode 0100 01da
// RQ2 - left rotate: bit7 wraps into bit0
// RQ3 - left rotate updates only negative and zero
// RQ4 - destination bit 0 accumulator, 1 register
// RQ5 - bank bit 0 access bank, 1 bank pointer
// RQ6 - extended set, bank 0, f<=5Fh: indexed
// RQ7 - right rotate through carry, updates C N Z
// RQ8 - one word: decode, read, process, write phases
//
// The AXI4-Lite slave port and the address map were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module byte_rotate_unit #(
    parameter int MEM_DEPTH = 4096
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    localparam int MEM_AW = $clog2(MEM_DEPTH);

    generate
        if (MEM_DEPTH < 256 || MEM_DEPTH > 4096 || (1 << MEM_AW) != MEM_DEPTH) begin : g_chk
            $error("MEM_DEPTH must be a power of two from 256 to 4096");
        end
    endgenerate

    // ****************************************
    // state
    // ****************************************
    rotate_pkg::phase_e phase;
    logic [15:0]        instr;
    logic [11:0]        eff_addr;
    logic               dest_reg;
    logic               op_right;
    logic [7:0]         operand;
    logic [7:0]         result;
    logic               res_carry;
    logic               carry;
    logic               zero;
    logic               neg;
    logic               illegal;
    logic               ext_en;
    logic [7:0]         accum;
    logic [3:0]         bank_pointer;
    logic [11:0]        index_base;
    logic [11:0]        mem_addr;
    logic [7:0]         mem [MEM_DEPTH];

    logic               aw_have;
    logic               w_have;
    logic [7:0]         wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;
    logic               wr_fire;
    logic               wr_known;
    logic [31:0]        rd_mux;
    logic               rd_known;

    logic [5:0]         dec_opc;
    logic               dec_legal;
    logic [7:0]         dec_file;
    logic [11:0]        dec_addr;

    // ****************************************
    // write channels
    // ****************************************
    assign wr_fire = aw_have && w_have && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            awready <= 1'b1;
            wr_addr <= rotate_pkg::BYTE_RESET;
        end else if (awvalid && awready) begin
            aw_have <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have  <= 1'b0;
            wready  <= 1'b1;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (wvalid && wready) begin
            w_have  <= 1'b1;
            wready  <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    always_comb begin
        unique case (wr_addr)
            rotate_pkg::OFS_CTRL, rotate_pkg::OFS_INSTR, rotate_pkg::OFS_STATUS,
            rotate_pkg::OFS_ACCUM, rotate_pkg::OFS_BANK, rotate_pkg::OFS_INDEX,
            rotate_pkg::OFS_MEM_ADDR, rotate_pkg::OFS_MEM_DATA: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= rotate_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_known ? rotate_pkg::RESP_OKAY : rotate_pkg::RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // software-owned configuration
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_en       <= 1'b0;
            bank_pointer <= rotate_pkg::ACCESS_LOW_BANK;
            index_base   <= rotate_pkg::ADDR_RESET;
            mem_addr     <= rotate_pkg::ADDR_RESET;
        end else if (wr_fire) begin
            unique case (wr_addr)
                rotate_pkg::OFS_CTRL:
                    ext_en <= wr_strb[0] ? wr_data[rotate_pkg::CTRL_EXT_BIT] : ext_en;
                rotate_pkg::OFS_BANK: bank_pointer <= wr_strb[0] ? wr_data[3:0] : bank_pointer;
                rotate_pkg::OFS_INDEX:
                    index_base <= {wr_strb[1] ? wr_data[11:8] : index_base[11:8],
                                   wr_strb[0] ? wr_data[7:0] : index_base[7:0]};
                rotate_pkg::OFS_MEM_ADDR:
                    mem_addr <= {wr_strb[1] ? wr_data[11:8] : mem_addr[11:8],
                                 wr_strb[0] ? wr_data[7:0] : mem_addr[7:0]};
                default: ;
            endcase
        end
    end

    // ****************************************
    // decode and operand addressing
    // ****************************************
    assign dec_opc   = instr[rotate_pkg::INSTR_OPC_LSB +: rotate_pkg::OPC_W];
    assign dec_file  = instr[rotate_pkg::FILE_W-1:0];
    assign dec_legal = (dec_opc == rotate_pkg::OPC_ROTATE_LEFT_PLAIN) ||      // RQ1
                       (dec_opc == rotate_pkg::OPC_ROTATE_RIGHT_VIA_CARRY);   // RQ7

    always_comb begin
        if (instr[rotate_pkg::INSTR_BANK_BIT]) begin
            dec_addr = {bank_pointer, dec_file};                                         // RQ5
        end else if (ext_en && dec_file <= rotate_pkg::ACCESS_LOW_MAX) begin
            dec_addr = 12'(index_base + {rotate_pkg::ACCESS_LOW_BANK, dec_file});        // RQ6
        end else if (dec_file <= rotate_pkg::ACCESS_LOW_MAX) begin
            dec_addr = {rotate_pkg::ACCESS_LOW_BANK, dec_file};                          // RQ5
        end else begin
            dec_addr = {rotate_pkg::ACCESS_HIGH_BANK, dec_file};                         // RQ5
        end
    end

    // ****************************************
    // instruction phase sequence
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= rotate_pkg::PH_IDLE;
        end else begin
            unique case (phase)
                rotate_pkg::PH_IDLE: begin
                    if (wr_fire && wr_addr == rotate_pkg::OFS_INSTR) begin
                        phase <= rotate_pkg::PH_DECODE;                                  // RQ8
                    end
                end
                rotate_pkg::PH_DECODE:  phase <= dec_legal ? rotate_pkg::PH_READ
                                                           : rotate_pkg::PH_IDLE;        // RQ8
                rotate_pkg::PH_READ:    phase <= rotate_pkg::PH_PROCESS;                 // RQ8
                rotate_pkg::PH_PROCESS: phase <= rotate_pkg::PH_WRITE;                   // RQ8
                rotate_pkg::PH_WRITE:   phase <= rotate_pkg::PH_IDLE;                    // RQ8
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr    <= rotate_pkg::INSTR_RESET;
            illegal  <= 1'b0;
            eff_addr <= rotate_pkg::ADDR_RESET;
            dest_reg <= 1'b1;
            op_right <= 1'b0;
        end else if (phase == rotate_pkg::PH_IDLE && wr_fire
                     && wr_addr == rotate_pkg::OFS_INSTR) begin
            instr <= {wr_strb[1] ? wr_data[15:8] : instr[15:8],
                      wr_strb[0] ? wr_data[7:0] : instr[7:0]};
        end else if (phase == rotate_pkg::PH_DECODE) begin
            illegal  <= !dec_legal;
            eff_addr <= dec_addr;
            dest_reg <= instr[rotate_pkg::INSTR_DEST_BIT];                                // RQ4
            op_right <= (dec_opc == rotate_pkg::OPC_ROTATE_RIGHT_VIA_CARRY);
        end
    end

    // ****************************************
    // read and process
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            operand   <= rotate_pkg::BYTE_RESET;
            result    <= rotate_pkg::BYTE_RESET;
            res_carry <= 1'b0;
        end else if (phase == rotate_pkg::PH_READ) begin
            operand <= mem[eff_addr[MEM_AW-1:0]];
        end else if (phase == rotate_pkg::PH_PROCESS) begin
            if (op_right) begin
                result    <= {carry, operand[7:1]};                                       // RQ7
                res_carry <= operand[0];                                                  // RQ7
            end else begin
                result    <= {operand[6:0], operand[7]};                                  // RQ2
                res_carry <= carry;                                                       // RQ3
            end
        end
    end

    // ****************************************
    // destination write and flags
    // ****************************************
    always_ff @(posedge aclk) begin
        if (phase == rotate_pkg::PH_WRITE && dest_reg) begin
            mem[eff_addr[MEM_AW-1:0]] <= result;                                          // RQ4
        end else if (wr_fire && wr_addr == rotate_pkg::OFS_MEM_DATA && wr_strb[0]) begin
            mem[mem_addr[MEM_AW-1:0]] <= wr_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accum <= rotate_pkg::BYTE_RESET;
        end else if (phase == rotate_pkg::PH_WRITE && !dest_reg) begin
            accum <= result;                                                              // RQ4
        end else if (wr_fire && wr_addr == rotate_pkg::OFS_ACCUM && wr_strb[0]) begin
            accum <= wr_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry <= 1'b0;
            zero  <= 1'b0;
            neg   <= 1'b0;
        end else if (phase == rotate_pkg::PH_WRITE) begin
            carry <= res_carry;                                                           // RQ3 RQ7
            zero  <= (result == rotate_pkg::BYTE_RESET);                                  // RQ3 RQ7
            neg   <= result[7];                                                           // RQ3 RQ7
        end else if (wr_fire && wr_addr == rotate_pkg::OFS_STATUS && wr_strb[0]) begin
            carry <= wr_data[rotate_pkg::ST_CARRY_BIT];
            zero  <= wr_data[rotate_pkg::ST_ZERO_BIT];
            neg   <= wr_data[rotate_pkg::ST_NEG_BIT];
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_comb begin
        rd_mux   = 32'h0000_0000;
        rd_known = 1'b1;
        unique case (araddr)
            rotate_pkg::OFS_CTRL:     rd_mux[rotate_pkg::CTRL_EXT_BIT] = ext_en;
            rotate_pkg::OFS_INSTR:    rd_mux[15:0] = instr;
            rotate_pkg::OFS_STATUS: begin
                rd_mux[rotate_pkg::ST_CARRY_BIT]   = carry;
                rd_mux[rotate_pkg::ST_ZERO_BIT]    = zero;
                rd_mux[rotate_pkg::ST_NEG_BIT]     = neg;
                rd_mux[rotate_pkg::ST_BUSY_BIT]    = (phase != rotate_pkg::PH_IDLE);
                rd_mux[rotate_pkg::ST_ILLEGAL_BIT] = illegal;
            end
            rotate_pkg::OFS_ACCUM:    rd_mux[7:0]  = accum;
            rotate_pkg::OFS_BANK:     rd_mux[3:0]  = bank_pointer;
            rotate_pkg::OFS_INDEX:    rd_mux[11:0] = index_base;
            rotate_pkg::OFS_MEM_ADDR: rd_mux[11:0] = mem_addr;
            rotate_pkg::OFS_MEM_DATA: rd_mux[7:0]  = mem[mem_addr[MEM_AW-1:0]];
            rotate_pkg::OFS_EFF_ADDR: rd_mux[11:0] = eff_addr;
            default:                  rd_known     = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= rotate_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= rd_known ? rotate_pkg::RESP_OKAY : rotate_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule

`default_nettype wire

/* hw/rotate_pkg.sv */
// Purpose: shared constants and types for the byte rotate unit
// Assumes: 32-bit AXI4-Lite register access, 12-bit data memory address
// Notes:   offsets are byte addresses on the register bus

package rotate_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_ADDR_W = 12;
    localparam int BANK_W      = 4;
    localparam int FILE_W      = 8;
    localparam int REG_ADDR_W  = 8;
    localparam int INSTR_W     = 16;
    localparam int OPC_W       = 6;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_INSTR    = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_ACCUM    = 8'h0C;
    localparam logic [7:0] OFS_BANK     = 8'h10;
    localparam logic [7:0] OFS_INDEX    = 8'h14;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h18;
    localparam logic [7:0] OFS_MEM_DATA = 8'h1C;
    localparam logic [7:0] OFS_EFF_ADDR = 8'h20;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_EXT_BIT   = 0;
    localparam int ST_CARRY_BIT   = 0;
    localparam int ST_ZERO_BIT    = 2;
    localparam int ST_NEG_BIT     = 4;
    localparam int ST_BUSY_BIT    = 8;
    localparam int ST_ILLEGAL_BIT = 9;
    localparam int INSTR_BANK_BIT = 8;
    localparam int INSTR_DEST_BIT = 9;
    localparam int INSTR_OPC_LSB  = 10;

    // ****************************************
    // opcodes and addressing constants
    // ****************************************
    localparam logic [5:0] OPC_ROTATE_LEFT_PLAIN      = 6'h11;
    localparam logic [5:0] OPC_ROTATE_RIGHT_VIA_CARRY = 6'h0C;
    localparam logic [7:0] ACCESS_LOW_MAX             = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK           = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK            = 4'h0;

    // ****************************************
    // reset values, bus responses and phase type
    // ****************************************
    localparam logic [15:0] INSTR_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [11:0] ADDR_RESET  = 12'h000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } phase_e;

endpackage

/* testbench/byte_rotate_unit_monitor.sv */
// Purpose: bus protocol checker for byte_rotate_unit
// Assumes: single clock aclk, synchronous active-low reset aresetn
// Notes:   sees only the top module ports
`timescale 1ns/1ps
`default_nettype none
module rotate_monitor #(
    parameter int MEM_DEPTH = 4096
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready
);
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    r_latency_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    b_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("read accepted while answer pending");
    aw_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while answer pending");
    r_single_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    rd_unmapped_a: assert property (arvalid && arready && araddr > 8'h20
        |=> rresp == rotate_pkg::RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    wr_unmapped_a: assert property (awvalid && awready && wvalid && wready
        && awaddr > 8'h20 |-> ##2 bvalid && bresp == rotate_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    rd_okay_a: assert property (arvalid && arready && araddr <= 8'h20
        && araddr[1:0] == 2'h0 |=> rresp == rotate_pkg::RESP_OKAY)
        else $error("mapped read refused");

    wr_c: cover property (bvalid && bready);
    rd_c: cover property (rvalid && rready);
    err_c: cover property (rvalid && rresp == rotate_pkg::RESP_SLVERR);
endmodule
bind byte_rotate_unit rotate_monitor #(.MEM_DEPTH(MEM_DEPTH)) mon (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench for byte_rotate_unit
// Assumes: AXI4-Lite master driven at rising edges
// Notes:   expected reads queued by drivers, compared by a watcher
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, prev_st;
    logic [3:0]  wstrb;
    logic [2:0]  awprot, arprot;
    logic [1:0]  bresp, rresp;
    logic [33:0] qr[$];
    logic [1:0]  qw[$];
    int          n_errors, n_compared, cyc;

    byte_rotate_unit dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        qw.push_back(er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        qr.push_back({er, d});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    // ****************************************
    // one rotate with random operands
    // ****************************************
    task automatic run_case(input int i);
        logic [7:0]  v, f, acc, res, st;
        logic [3:0]  bank;
        logic [11:0] idx, ea;
        logic        a, d, ext, left, c, z, n;
        {ext, d, a, left} = 4'(i);
        v = 8'($urandom);
        acc = 8'($urandom);
        bank = 4'($urandom);
        idx = 12'($urandom);
        st = 8'($urandom) & 8'h15;
        f = (i % 3 == 0) ? 8'h5F : (i % 3 == 1) ? 8'h60 : 8'($urandom);
        if (a) ea = {bank, f};
        else if (ext && f <= 8'h5F) ea = idx + {4'h0, f};
        else ea = {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
        c = st[0];
        if (left) res = {v[6:0], v[7]};
        else begin
            res = {c, v[7:1]};
            c = v[0];
        end
        z = (res == 8'h00);
        n = res[7];
        wr(rotate_pkg::OFS_CTRL, {31'h0, ext}, rotate_pkg::RESP_OKAY);
        wr(rotate_pkg::OFS_BANK, {28'h0, bank}, rotate_pkg::RESP_OKAY);
        wr(rotate_pkg::OFS_INDEX, {20'h0, idx}, rotate_pkg::RESP_OKAY);
        wr(rotate_pkg::OFS_MEM_ADDR, {20'h0, ea}, rotate_pkg::RESP_OKAY);
        wr(rotate_pkg::OFS_MEM_DATA, {24'h0, v}, rotate_pkg::RESP_OKAY);
        wr(rotate_pkg::OFS_ACCUM, {24'h0, acc}, rotate_pkg::RESP_OKAY);
        wr(rotate_pkg::OFS_STATUS, {24'h0, st}, rotate_pkg::RESP_OKAY);
        wr(rotate_pkg::OFS_INSTR, {16'h0, left ? rotate_pkg::OPC_ROTATE_LEFT_PLAIN
           : rotate_pkg::OPC_ROTATE_RIGHT_VIA_CARRY, d, a, f}, rotate_pkg::RESP_OKAY);
        repeat (6) @(posedge aclk);
        prev_st = {27'h0, n, 1'b0, z, 1'b0, c};
        rd(rotate_pkg::OFS_MEM_DATA, {24'h0, d ? res : v}, rotate_pkg::RESP_OKAY);
        rd(rotate_pkg::OFS_ACCUM, {24'h0, d ? acc : res}, rotate_pkg::RESP_OKAY);
        rd(rotate_pkg::OFS_STATUS, prev_st, rotate_pkg::RESP_OKAY);
        rd(rotate_pkg::OFS_EFF_ADDR, {20'h0, ea}, rotate_pkg::RESP_OKAY);
    endtask

    // ****************************************
    // clock, watcher, timeout, main sequence
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (aresetn && rvalid && rready) chk({rresp, rdata}, qr.pop_front());
        if (aresetn && bvalid && bready) chk({32'h0, bresp}, {32'h0, qw.pop_front()});
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, awprot, arprot} = 22'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        void'($urandom(27408));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 7; k++) rd(8'(k * 4), 32'h0, rotate_pkg::RESP_OKAY);
        for (int i = 0; i < 16; i++) run_case(i);
        wr(rotate_pkg::OFS_INSTR, 32'h0000FC00, rotate_pkg::RESP_OKAY);
        repeat (6) @(posedge aclk);
        rd(rotate_pkg::OFS_STATUS, prev_st | 32'h200, rotate_pkg::RESP_OKAY);
        rd(8'h40, 32'h0, rotate_pkg::RESP_SLVERR);
        wr(8'h40, 32'h1, rotate_pkg::RESP_SLVERR);
        repeat (4) @(posedge aclk);
        report_and_stop();
    end
endmodule
`default_nettype wire
